// [hdl/rlt_pkg.sv]
// package for the reader link turnaround timers: register map, reset values,
// field positions, timing constants and the analog control carrier.
// assumes a single 250 MHz clock domain and the device register port.
package rlt_pkg;

   // ***********************************************************************
   // register offsets
   // ***********************************************************************
   localparam logic [7:0] ADDR_TX_DELAY_TIME      = 8'h06;
   localparam logic [7:0] ADDR_NO_REPLY_TIMEOUT   = 8'h07;
   localparam logic [7:0] ADDR_RX_BLANKING_TIME   = 8'h08;
   localparam logic [7:0] ADDR_RX_FILTER_SETUP    = 8'h09;
   localparam logic [7:0] ADDR_RX_GAIN_MIXER      = 8'h0a;
   localparam logic [7:0] ADDR_IRQ_STATUS         = 8'h0c;

   // ***********************************************************************
   // reset values
   // ***********************************************************************
   localparam logic [7:0] RST_TX_DELAY_TIME       = 8'h00;
   localparam logic [7:0] RST_NO_REPLY_TIMEOUT    = 8'h07;
   localparam logic [7:0] RST_RX_BLANKING_TIME    = 8'h07;
   localparam logic [7:0] RST_RX_FILTER_SETUP     = 8'h41;
   localparam logic [7:0] RST_RX_GAIN_MIXER       = 8'h01;
   localparam logic [7:0] RST_IRQ_STATUS          = 8'h00;

   // ***********************************************************************
   // field positions
   // ***********************************************************************
   localparam int FILT_RO_MSB         = 7;   // upper nibble is read only
   localparam int FILT_RO_LSB         = 4;
   localparam int FILT_COUPLING_BIT   = 3;
   localparam int FILT_LOWSIDE_BIT    = 2;
   localparam int FILT_TUNE_MSB       = 1;
   localparam int FILT_TUNE_LSB       = 0;
   localparam int GAIN_COARSE_MSB     = 7;
   localparam int GAIN_COARSE_LSB     = 5;
   localparam int GAIN_HYST_MSB       = 4;
   localparam int GAIN_HYST_LSB       = 3;
   localparam int MIX_SINGLE_BIT      = 2;
   localparam int MIX_LOWSUP_BIT      = 1;
   localparam int MIX_ATTEN_BIT       = 0;
   localparam int IRQ_NO_REPLY_BIT    = 0;

   // ***********************************************************************
   // timing
   // ***********************************************************************
   localparam int CLK_PERIOD_NS       = 4;
   localparam int STEP_SHORT_NS       = 6400;   // 6.4 us step
   localparam int STEP_LONG_NS        = 25600;  // 25.6 us step
   localparam int STEP_SHORT_CYCLES   = STEP_SHORT_NS / CLK_PERIOD_NS;
   localparam int STEP_LONG_CYCLES    = STEP_LONG_NS / CLK_PERIOD_NS;
   localparam int PRESCALE_W          = 13;
   localparam logic [3:0] REPLY_DETECT_PERIODS = 4'h6;  // lower end of 6..10

   // ***********************************************************************
   // analog control carrier
   // ***********************************************************************
   typedef struct packed {
      logic       coupling_speedup;
      logic       low_side_filter_open;
      logic       filter_tune_hi;
      logic       filter_tune_lo;
      logic [2:0] gain_coarse_cut;
      logic [1:0] hysteresis_cut;
      logic       mixer_single_ended;
      logic       mixer_low_supply_adapt;
      logic       mixer_attenuate;
   } rlt_rx_analog_s;

endpackage

// [hdl/rlt_sync2.sv]
// two flip-flop synchroniser for one level from outside the clock domain.
// assumes the input changes slowly compared with the clock.
`timescale 1ns/10ps
module rlt_sync2 (
   input  wire logic clk_in,
   input  wire logic reset_in,
   input  wire logic ce_in,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_reg;

   // ***********************************************************************
   // two stages, first stage read only by the second
   // ***********************************************************************
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         meta_reg <= 1'b0;
         sync_out <= 1'b0;
      end else if (ce_in) begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// [hdl/rlt_step_timer.sv]
// one down-counting turnaround timer with its own step prescaler.
// assumes start and abort are single-cycle pulses from the same clock.
`timescale 1ns/10ps
module rlt_step_timer #(
   parameter int TICK_CYCLES = rlt_pkg::STEP_SHORT_CYCLES
) (
   input  wire logic       clk_in,
   input  wire logic       reset_in,
   input  wire logic       ce_in,
   input  wire logic       start_in,
   input  wire logic       abort_in,
   input  wire logic [7:0] value_in,
   output logic            busy_out,
   output logic            done_out
);
   localparam logic [rlt_pkg::PRESCALE_W-1:0] PRE_LAST = rlt_pkg::PRESCALE_W'(TICK_CYCLES - 1);

   logic [rlt_pkg::PRESCALE_W-1:0] pre_reg;
   logic [7:0]                     remain_reg;
   logic                           done_reg;
   wire                            tick_w    = (pre_reg == PRE_LAST);
   wire                            last_w    = tick_w && (remain_reg == 8'h01);
   wire                            zero_go_w = start_in && (value_in == 8'h00);

   assign busy_out = (remain_reg != 8'h00);
   assign done_out = done_reg;

   // ***********************************************************************
   // load on start, restart mid-count, step down once per tick
   // ***********************************************************************
   // the prescaler restarts with the timer so the first step is a full step
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pre_reg    <= '0;
         remain_reg <= 8'h00;
         done_reg   <= 1'b0;
      end else if (ce_in) begin
         done_reg <= 1'b0;
         if (abort_in) begin
            remain_reg <= 8'h00;
            pre_reg    <= '0;
         end else if (start_in) begin
            remain_reg <= value_in;
            pre_reg    <= '0;
            done_reg   <= zero_go_w;
         end else if (busy_out) begin
            pre_reg <= tick_w ? '0 : pre_reg + 1'b1;
            if (tick_w) begin
               remain_reg <= remain_reg - 8'h01;
            end
            done_reg <= last_w;
         end
      end
   end
endmodule

// [hdl/rlt_turnaround.sv]
// top of the reader link turnaround timers: register file for 06..0a and the
// no-reply status, the three link timers and the receiver analog controls.
// assumes tx/rx framing events come from on-chip logic on clk_in, while the
// chip enable and the digitised receive input arrive from pins.
//
// Overview of operation
// - after reception ends, wait tx delay register times 6.4us before sending
// - tx delay of zero means no wait before sending
// - no-reply timer starts when a transmission ends
// - no-reply timeout is register value times 25.6us
// - flag no reply if timeout expires before 6-10 link periods seen
// - receive input ignored for a blanking interval after transmission ends
// - blanking interval is register value times 6.4us
// - blanking register zero enables receiver right after transmission
// - tx delay register presets to zero on reset or chip disable
// - no-reply register presets to seven on reset or chip disable
// - filter setup bit 3 doubles first-stage coupling settling speed
// - filter setup bit 2 opens filter low-frequency side for FM0
// - filter setup bits 1:0 pick the filter tuning band
// - gain bits 7:5 cut receiver gain in seven 3dB steps
// - gain bits 4:3 cut digitiser hysteresis gain in three 5dB steps
// - gain bit 2 picks single-ended or differential mixer input
// - no-reply event shows as status bit 0
// - status clears at end of the host read phase, dropping the request
`timescale 1ns/10ps
module rlt_turnaround #(
   parameter int NO_REPLY_TICK_CYCLES = rlt_pkg::STEP_LONG_CYCLES
) (
   input  wire logic                    clk_in,
   input  wire logic                    reset_in,
   input  wire logic                    ce_in,
   input  wire logic                    chip_en_in,
   input  wire logic [7:0]              reg_addr_in,
   input  wire logic [7:0]              reg_wdata_in,
   input  wire logic                    reg_write_in,
   input  wire logic                    reg_read_in,
   input  wire logic                    read_phase_end_in,
   input  wire logic                    rx_end_in,
   input  wire logic                    tx_end_in,
   input  wire logic                    rx_data_in,
   output logic [7:0]                   reg_rdata_out,
   output logic                         tx_hold_out,
   output logic                         rx_enable_out,
   output logic                         reply_seen_out,
   output logic                         no_reply_irq_out,
   output rlt_pkg::rlt_rx_analog_s      rx_analog_out
);

   // ***********************************************************************
   // pin synchronisers
   // ***********************************************************************
   logic [1:0] pin_raw_w;
   logic [1:0] pin_sync_w;

   assign pin_raw_w = {chip_en_in, rx_data_in};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         rlt_sync2 u_sync (
            .clk_in   (clk_in),
            .reset_in (reset_in),
            .ce_in    (ce_in),
            .async_in (pin_raw_w[gi]),
            .sync_out (pin_sync_w[gi])
         );
      end
   endgenerate

   wire chip_en_w = pin_sync_w[1];
   wire rx_bit_w  = pin_sync_w[0];

   // chip disable acts like reset for registers and timers
   wire preset_w  = !chip_en_w;

   // ***********************************************************************
   // registers
   // ***********************************************************************
   logic [7:0] tx_delay_time_reg;
   logic [7:0] no_reply_timeout_reg;
   logic [7:0] rx_blanking_time_reg;
   logic [3:0] rx_filter_setup_reg;
   logic [7:0] rx_gain_mixer_reg;
   logic [7:0] irq_status_reg;
   logic [7:0] rdata_reg;

   // write strobes per register
   wire wr_txd_w  = reg_write_in && (reg_addr_in == rlt_pkg::ADDR_TX_DELAY_TIME);
   wire wr_nrp_w  = reg_write_in && (reg_addr_in == rlt_pkg::ADDR_NO_REPLY_TIMEOUT);
   wire wr_blk_w  = reg_write_in && (reg_addr_in == rlt_pkg::ADDR_RX_BLANKING_TIME);
   wire wr_flt_w  = reg_write_in && (reg_addr_in == rlt_pkg::ADDR_RX_FILTER_SETUP);
   wire wr_gain_w = reg_write_in && (reg_addr_in == rlt_pkg::ADDR_RX_GAIN_MIXER);

   // configuration registers, preset on reset or chip disable
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         tx_delay_time_reg    <= rlt_pkg::RST_TX_DELAY_TIME;
         no_reply_timeout_reg <= rlt_pkg::RST_NO_REPLY_TIMEOUT;
         rx_blanking_time_reg <= rlt_pkg::RST_RX_BLANKING_TIME;
         rx_filter_setup_reg  <= rlt_pkg::RST_RX_FILTER_SETUP[3:0];
         rx_gain_mixer_reg    <= rlt_pkg::RST_RX_GAIN_MIXER;
      end else if (ce_in) begin
         if (preset_w) begin
            tx_delay_time_reg    <= rlt_pkg::RST_TX_DELAY_TIME;
            no_reply_timeout_reg <= rlt_pkg::RST_NO_REPLY_TIMEOUT;
            rx_blanking_time_reg <= rlt_pkg::RST_RX_BLANKING_TIME;
            rx_filter_setup_reg  <= rlt_pkg::RST_RX_FILTER_SETUP[3:0];
            rx_gain_mixer_reg    <= rlt_pkg::RST_RX_GAIN_MIXER;
         end else begin
            if (wr_txd_w) begin
               tx_delay_time_reg <= reg_wdata_in;
            end
            if (wr_nrp_w) begin
               no_reply_timeout_reg <= reg_wdata_in;
            end
            if (wr_blk_w) begin
               rx_blanking_time_reg <= reg_wdata_in;
            end
            if (wr_flt_w) begin
               rx_filter_setup_reg <= reg_wdata_in[3:0];
            end
            if (wr_gain_w) begin
               rx_gain_mixer_reg <= reg_wdata_in;
            end
         end
      end
   end

   // ***********************************************************************
   // link timers
   // ***********************************************************************
   logic txd_busy_w;
   logic blk_busy_w;
   logic nrp_busy_w;
   logic nrp_done_w;
   logic reply_abort_w;

   // delay before the next transmission, counted from end of reception
   rlt_step_timer #(
      .TICK_CYCLES (rlt_pkg::STEP_SHORT_CYCLES)
   ) u_tx_delay (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .ce_in    (ce_in),
      .start_in (rx_end_in),
      .abort_in (preset_w),
      .value_in (tx_delay_time_reg),
      .busy_out (txd_busy_w),
      .done_out ()
   );

   // receiver blanking, counted from end of transmission
   rlt_step_timer #(
      .TICK_CYCLES (rlt_pkg::STEP_SHORT_CYCLES)
   ) u_rx_blank (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .ce_in    (ce_in),
      .start_in (tx_end_in),
      .abort_in (preset_w),
      .value_in (rx_blanking_time_reg),
      .busy_out (blk_busy_w),
      .done_out ()
   );

   // no-reply watchdog on the long step, counted from end of transmission
   rlt_step_timer #(
      .TICK_CYCLES (NO_REPLY_TICK_CYCLES)
   ) u_no_reply (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .ce_in    (ce_in),
      .start_in (tx_end_in),
      .abort_in (reply_abort_w || preset_w),
      .value_in (no_reply_timeout_reg),
      .busy_out (nrp_busy_w),
      .done_out (nrp_done_w)
   );

   // a zero value never makes the timer busy, so no wait and no blanking
   assign tx_hold_out   = txd_busy_w;
   assign rx_enable_out = !blk_busy_w && chip_en_w;

   // ***********************************************************************
   // reply detection: count link periods once blanking is over
   // ***********************************************************************
   logic       rx_prev_reg;
   logic [3:0] period_cnt_reg;
   logic       reply_seen_reg;

   wire rx_rise_w   = rx_bit_w && !rx_prev_reg && rx_enable_out;
   wire count_on_w  = nrp_busy_w && !reply_seen_reg;
   wire period_hit_w = count_on_w && rx_rise_w &&
                       (period_cnt_reg == rlt_pkg::REPLY_DETECT_PERIODS - 4'h1);

   // a detected reply stops the watchdog; a new frame end restarts it instead
   assign reply_abort_w  = period_hit_w && !tx_end_in;
   assign reply_seen_out = reply_seen_reg;

   // rising edges are counted only while the watchdog runs
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rx_prev_reg    <= 1'b0;
         period_cnt_reg <= 4'h0;
         reply_seen_reg <= 1'b0;
      end else if (ce_in) begin
         rx_prev_reg <= rx_bit_w;
         if (tx_end_in || preset_w) begin
            period_cnt_reg <= 4'h0;
            reply_seen_reg <= 1'b0;
         end else if (period_hit_w) begin
            reply_seen_reg <= 1'b1;
         end else if (count_on_w && rx_rise_w) begin
            period_cnt_reg <= period_cnt_reg + 4'h1;
         end
      end
   end

   // ***********************************************************************
   // no-reply status and read port
   // ***********************************************************************
   wire addr_flt_w = (reg_addr_in == rlt_pkg::ADDR_RX_FILTER_SETUP);
   logic [7:0] rd_mux_w;
   logic [7:0] irq_set_w;

   assign irq_set_w = {7'h00, nrp_done_w} << rlt_pkg::IRQ_NO_REPLY_BIT;

   // read mux, unmapped offsets read zero
   always_comb begin
      case (reg_addr_in)
         rlt_pkg::ADDR_TX_DELAY_TIME:    rd_mux_w = tx_delay_time_reg;
         rlt_pkg::ADDR_NO_REPLY_TIMEOUT: rd_mux_w = no_reply_timeout_reg;
         rlt_pkg::ADDR_RX_BLANKING_TIME: rd_mux_w = rx_blanking_time_reg;
         rlt_pkg::ADDR_RX_GAIN_MIXER:    rd_mux_w = rx_gain_mixer_reg;
         rlt_pkg::ADDR_IRQ_STATUS:       rd_mux_w = irq_status_reg;
         default: begin
            rd_mux_w = addr_flt_w ?
                       {rlt_pkg::RST_RX_FILTER_SETUP[rlt_pkg::FILT_RO_MSB:rlt_pkg::FILT_RO_LSB],
                        rx_filter_setup_reg} : 8'h00;
         end
      endcase
   end

   // status: a new event in the clearing cycle survives the clear
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         irq_status_reg <= rlt_pkg::RST_IRQ_STATUS;
         rdata_reg      <= 8'h00;
      end else if (ce_in) begin
         if (preset_w) begin
            irq_status_reg <= rlt_pkg::RST_IRQ_STATUS;
         end else if (read_phase_end_in) begin
            irq_status_reg <= irq_set_w;
         end else begin
            irq_status_reg <= irq_status_reg | irq_set_w;
         end
         if (reg_read_in) begin
            rdata_reg <= rd_mux_w;
         end
      end
   end

   assign reg_rdata_out    = rdata_reg;
   assign no_reply_irq_out = irq_status_reg[rlt_pkg::IRQ_NO_REPLY_BIT];

   // ***********************************************************************
   // receiver analog controls, straight from flops
   // ***********************************************************************
   assign rx_analog_out.coupling_speedup       = rx_filter_setup_reg[rlt_pkg::FILT_COUPLING_BIT];
   assign rx_analog_out.low_side_filter_open   = rx_filter_setup_reg[rlt_pkg::FILT_LOWSIDE_BIT];
   assign rx_analog_out.filter_tune_hi         = rx_filter_setup_reg[rlt_pkg::FILT_TUNE_MSB];
   assign rx_analog_out.filter_tune_lo         = rx_filter_setup_reg[rlt_pkg::FILT_TUNE_LSB];
   assign rx_analog_out.gain_coarse_cut        =
      rx_gain_mixer_reg[rlt_pkg::GAIN_COARSE_MSB:rlt_pkg::GAIN_COARSE_LSB];
   assign rx_analog_out.hysteresis_cut         =
      rx_gain_mixer_reg[rlt_pkg::GAIN_HYST_MSB:rlt_pkg::GAIN_HYST_LSB];
   assign rx_analog_out.mixer_single_ended     = rx_gain_mixer_reg[rlt_pkg::MIX_SINGLE_BIT];
   // no interlock with the supply bit: that register lives elsewhere
   assign rx_analog_out.mixer_low_supply_adapt = rx_gain_mixer_reg[rlt_pkg::MIX_LOWSUP_BIT];
   assign rx_analog_out.mixer_attenuate        = rx_gain_mixer_reg[rlt_pkg::MIX_ATTEN_BIT];

endmodule

// [testbench/rlt_turnaround_asserts.sv]
// concurrent checks on the turnaround timer ports.
// assumes one clk_in domain, bound into rlt_turnaround below.
`timescale 1ns/10ps
module rlt_turnaround_chk (
   input wire logic       clk_in,
   input wire logic       reset_in,
   input wire logic       chip_en_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic       reg_read_in,
   input wire logic       read_phase_end_in,
   input wire logic       rx_end_in,
   input wire logic       tx_end_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       tx_hold_out,
   input wire logic       rx_enable_out,
   input wire logic       reply_seen_out,
   input wire logic       no_reply_irq_out
);
   // ***************************
   // decode and sequences
   // ***************************
   logic unmapped;
   // offsets outside 06..0a and 0c read back zero
   assign unmapped = (reg_addr_in < 8'h06) | (reg_addr_in > 8'h0c) | (reg_addr_in == 8'h0b);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // a timer that has just begun
   sequence s_hold_begin;
      rx_end_in ##1 tx_hold_out;
   endsequence
   sequence s_blank_begin;
      tx_end_in ##1 !rx_enable_out;
   endsequence
   // ***************************
   // properties
   // ***************************
   chk_hold_min_run: assert property (s_hold_begin |-> tx_hold_out [*8])
      else $error("tx hold ended too early");
   chk_hold_needs_start: assert property (!tx_hold_out && !rx_end_in |=> !tx_hold_out)
      else $error("tx hold rose without reception end");
   chk_blank_min_run: assert property (s_blank_begin |-> !rx_enable_out [*8])
      else $error("blanking ended too early");
   // chip enable excluded: its fall drops the receiver as well
   chk_listen_stays_on: assert property (rx_enable_out && !tx_end_in && chip_en_in |=> rx_enable_out)
      else $error("receiver dropped without transmission end");
   chk_reply_window_clear: assert property (tx_end_in |=> !reply_seen_out)
      else $error("reply flag kept over new window");
   chk_no_irq_reply: assert property ($rose(no_reply_irq_out) |-> !reply_seen_out)
      else $error("no-reply raised after reply seen");
   chk_irq_sticky_flag: assert property (no_reply_irq_out && !read_phase_end_in && chip_en_in |=> no_reply_irq_out)
      else $error("no-reply flag dropped without read end");
   chk_rdata_holds: assert property (!reg_read_in |=> $stable(reg_rdata_out))
      else $error("read data changed without read");
   chk_unmapped_zero: assert property (reg_read_in && unmapped |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind rlt_turnaround rlt_turnaround_chk chk_i (.clk_in(clk_in), .reset_in(reset_in), .chip_en_in(chip_en_in),
   .reg_addr_in(reg_addr_in), .reg_read_in(reg_read_in), .read_phase_end_in(read_phase_end_in),
   .rx_end_in(rx_end_in), .tx_end_in(tx_end_in), .reg_rdata_out(reg_rdata_out), .tx_hold_out(tx_hold_out),
   .rx_enable_out(rx_enable_out), .reply_seen_out(reply_seen_out), .no_reply_irq_out(no_reply_irq_out));

// [testbench/rlt_tag_model.sv]
// tag stand-in on the air link: answers with a digitised subcarrier.
// assumes the bench calls reply() after the reader frame has ended.
`timescale 1ns/10ps
module rlt_tag_model (
   input  wire logic clk_in,
   output logic      rx_data_out
);
   // ***************************
   // reply generator
   // ***************************
   // idle low between frames, no carrier there
   initial rx_data_out = 1'b0;
   // half sets the link rate, so fast and slow tags both fit
   task automatic reply(input int periods, input int half);
      repeat (periods) begin
         repeat (half) @(posedge clk_in);
         #1 rx_data_out = 1'b1;
         repeat (half) @(posedge clk_in);
         #1 rx_data_out = 1'b0;
      end
   endtask
endmodule

// [testbench/rlt_turnaround_tb.sv]
// self-checking bench for the turnaround timers and their registers.
// assumes a short no-reply tick so the long timer stays quick to run.
`timescale 1ns/10ps
module rlt_turnaround_tb;
   // ***************************
   // signals and instances
   // ***************************
   localparam int TICK = 8;
   logic        clk_in, reset_in, chip_en_in, reg_write_in, reg_read_in;
   logic        read_phase_end_in, rx_end_in, tx_end_in, rx_data_in;
   logic        tx_hold_out, rx_enable_out, reply_seen_out, no_reply_irq_out;
   logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, p;
   logic [15:0] n;
   logic [7:0]  pats [4] = '{8'hff, 8'h00, 8'ha5, 8'h5a};
   int          mismatches, n_tests;
   rlt_pkg::rlt_rx_analog_s rx_analog_out;
   rlt_turnaround #(.NO_REPLY_TICK_CYCLES(TICK)) uut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1),
      .chip_en_in(chip_en_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .read_phase_end_in(read_phase_end_in),
      .rx_end_in(rx_end_in), .tx_end_in(tx_end_in), .rx_data_in(rx_data_in), .reg_rdata_out(reg_rdata_out),
      .tx_hold_out(tx_hold_out), .rx_enable_out(rx_enable_out), .reply_seen_out(reply_seen_out),
      .no_reply_irq_out(no_reply_irq_out), .rx_analog_out(rx_analog_out));
   rlt_tag_model tag (.clk_in(clk_in), .rx_data_out(rx_data_in));
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // ***************************
   // access tasks
   // ***************************
   task automatic tick;
      @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // strobes drop for a cycle so back-to-back calls never retrigger in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_write_in = 1'b1;
      tick;
      reg_write_in = 1'b0;
      tick;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      reg_addr_in = a;
      reg_read_in = 1'b1;
      tick;
      reg_read_in = 1'b0;
      tick;
      chk(16'(reg_rdata_out), 16'(exp));
   endtask
   // one-cycle event: 0 rx end, 1 tx end, 2 read phase end
   task automatic pulse(input int k);
      {read_phase_end_in, tx_end_in, rx_end_in} = 3'(1 << k);
      tick;
      {read_phase_end_in, tx_end_in, rx_end_in} = 3'h0;
   endtask
   // cycles for which tx hold (0) or blanking (1) stands after a start
   task automatic span(input int k, output logic [15:0] c);
      c = 0;
      while (((k == 0) ? tx_hold_out : !rx_enable_out) === 1'b1 && c < 16'd9000) begin
         c++;
         tick;
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ***************************
   // tests
   // ***************************
   initial begin
      {reset_in, chip_en_in, reg_write_in, reg_read_in, read_phase_end_in} = 5'h10;
      {rx_end_in, tx_end_in, reg_addr_in, reg_wdata_in} = 18'h0;
      mismatches = 0;
      n_tests = 0;
      repeat (10) @(posedge clk_in);
      #1 reset_in = 1'b0;
      chip_en_in = 1'b1;
      repeat (3) tick;
      rdc(8'h06, 8'h00);
      rdc(8'h07, 8'h07);
      rdc(8'h08, 8'h07);
      rdc(8'h09, 8'h41);
      rdc(8'h0a, 8'h01);
      rdc(8'h0c, 8'h00);
      chk(16'(rx_analog_out), 16'h0101);
      $display("test reset values done");
      // mixer supply bit 1 kept clear: the lowered supply is not in this block
      for (int i = 0; i < 4; i++) begin
         p = pats[i];
         wr(8'h09, p);
         wr(8'h0a, p & 8'hfd);
         rdc(8'h09, {4'h4, p[3:0]});
         rdc(8'h0a, p & 8'hfd);
         chk(16'(rx_analog_out), {4'h0, p[3:0], p & 8'hfd});
      end
      wr(8'h0c, 8'hff);
      rdc(8'h0c, 8'h00);
      wr(8'h0b, 8'hff);
      rdc(8'h0b, 8'h00);
      wr(8'h06, 8'h55);
      wr(8'h07, 8'h33);
      chip_en_in = 1'b0;
      repeat (5) tick;
      chip_en_in = 1'b1;
      repeat (3) tick;
      rdc(8'h06, 8'h00);
      rdc(8'h07, 8'h07);
      $display("test register fields done");
      wr(8'h06, 8'h02);
      pulse(0);
      span(0, n);
      chk(n, 16'd3200);
      wr(8'h06, 8'h00);
      pulse(0);
      span(0, n);
      chk(n, 16'd0);
      wr(8'h06, 8'h01);
      pulse(0);
      repeat (800) tick;
      pulse(0);
      span(0, n);
      chk(n, 16'd1600);
      $display("test tx delay done");
      wr(8'h08, 8'h01);
      pulse(1);
      span(1, n);
      chk(n, 16'd1600);
      wr(8'h08, 8'h00);
      pulse(1);
      span(1, n);
      chk(n, 16'd0);
      repeat (100) tick;
      $display("test blanking done");
      for (int v = 0; v < 3; v += 2) begin
         wr(8'h07, 8'(v));
         pulse(2);
         tick;
         chk(16'(no_reply_irq_out), 16'h0);
         pulse(1);
         n = 0;
         do begin
            tick;
            n++;
         end while (no_reply_irq_out !== 1'b1 && n < 16'd3000);
         chk(n, 16'(v * TICK + 1));
         rdc(8'h0c, 8'h01);
      end
      $display("test no-reply timeout done");
      wr(8'h07, 8'hff);
      for (int k = 5; k < 7; k++) begin
         pulse(2);
         pulse(1);
         tag.reply(k, 3);
         repeat (2100) tick;
         chk(16'(no_reply_irq_out), 16'(k == 5));
         chk(16'(reply_seen_out), 16'(k == 6));
      end
      $display("test reply detect done");
      complete_run;
   end
   // whole run is near 12000 cycles, so 50000 means a hang
   initial begin
      #200000;
      mismatches++;
      complete_run;
   end
endmodule
